//--- core/pcf_fanout.sv
// Purpose: Digital model of a zero-delay clock fan-out driver with test bypass.
// Assumes: Reference pins, loop enable and output enable are synchronous to clk.
// Notes:   The oscillator is modelled by dividing the measured reference period.
`timescale 1ns/1ps

module pcf_fanout #(
  parameter int unsigned LOCK_CYCLES = pcf_pkg::LOCK_MIN_CYC // Lock acquisition time.
) (
  input  wire logic                      clk,
  input  wire logic                      sys_rst,
  input  wire logic                      ce,
  input  wire logic                      ref_clk0,
  input  wire logic                      ref_clk1,
  input  wire logic                      ref_sel,
  input  wire logic                      loop_enable,
  input  wire logic [1:0]                fb_sel,
  input  wire logic                      oe_rst_n,
  output logic [pcf_pkg::MAIN_N-1:0]     main_clock_outputs,
  output logic                           inverted_clock_output,
  output logic                           half_rate_clock,
  output logic                           double_rate_clock,
  output logic                           clock_oe,
  output logic                           lock_out
);

  // ---------------------------------------------------------------------
  // Declarations
  // ---------------------------------------------------------------------
  logic                      ref_in;    // Selected reference level.
  logic                      rise_p;    // Reference rising edge.
  logic                      fall_p;    // Reference falling edge.
  logic [pcf_pkg::PER_W-1:0] period;    // Measured reference period.
  logic [pcf_pkg::PER_W-1:0] seg_len;   // Cycles per phase step.
  logic [pcf_pkg::PER_W-1:0] seg_r;     // Cycles spent in this phase step.
  logic [2:0]                ph_r;      // Eighths of one half-rate period.
  logic [2:0]                ph_nxt;    // Next phase.
  logic                      hold_r;    // Bypass outputs held low.
  logic                      half_bp_r; // Bypass half-rate divider.
  logic [pcf_pkg::LOCK_W-1:0] lock_cnt_r; // Time since acquisition began.
  pcf_pkg::pcf_lock_type     lock_st_r; // Loop lock state.
  pcf_pkg::pcf_fb_type       fb;        // Decoded feedback choice.
  logic                      main_v;    // Main clock value before registering.
  logic                      half_v;    // Half-rate value before registering.
  logic                      dbl_v;     // Double-rate value before registering.
  logic                      inv_v;     // Inverted output value.

  assign ref_in = ref_sel ? ref_clk1 : ref_clk0;
  // The unused code falls back to main feedback, the most common wiring.
  assign fb = (fb_sel == 2'b00) ? pcf_pkg::PCF_FB_HALF :
              (fb_sel == 2'b10) ? pcf_pkg::PCF_FB_DOUBLE : pcf_pkg::PCF_FB_MAIN;

  // ---------------------------------------------------------------------
  // Reference measurement
  // ---------------------------------------------------------------------
  pcf_ref_meter u_meter (
    .clk      (clk),
    .sys_rst  (sys_rst),
    .ce       (ce),
    .ref_in   (ref_in),
    .rise_p   (rise_p),
    .fall_p   (fall_p),
    .period_r (period)
  );

  // Rounds the phase to the nearest rising edge of the fed-back output,
  // so that output's rising edge lands on the reference rising edge.
  function automatic logic [2:0] pcf_align(input logic [2:0] ph,
                                           input pcf_pkg::pcf_fb_type f);
    logic [2:0] span;
    logic [2:0] sum;
    span = 3'h0;
    sum  = 3'h0;
    unique case (f)
      pcf_pkg::PCF_FB_HALF:   span = 3'h0; // Whole counter is one period.
      pcf_pkg::PCF_FB_MAIN:   span = 3'h4;
      pcf_pkg::PCF_FB_DOUBLE: span = 3'h2;
    endcase
    if (span == 3'h0)
      pcf_align = pcf_pkg::PH_ZERO;
    else
    begin
      sum       = ph + (span >> 1);
      pcf_align = sum & ~(span - 3'h1);
    end
  endfunction

  // ---------------------------------------------------------------------
  // Segment length: the fed-back output's period is one reference period,
  // and the phase counter takes two steps per double-rate period.
  // ---------------------------------------------------------------------
  always_comb
  begin
    seg_len = period;
    unique case (fb)
      pcf_pkg::PCF_FB_HALF:   seg_len = period >> 3;
      pcf_pkg::PCF_FB_MAIN:   seg_len = period >> 2;
      pcf_pkg::PCF_FB_DOUBLE: seg_len = period >> 1;
    endcase
    if (seg_len == '0)
      seg_len = pcf_pkg::SEG_ONE;
  end

  // Next phase: re-aligned on every reference rise, else stepped per segment.
  always_comb
  begin
    ph_nxt = ph_r;
    if (rise_p)
      ph_nxt = pcf_align(ph_r, fb);
    else if (seg_r + pcf_pkg::SEG_ONE >= seg_len)
      ph_nxt = ph_r + 3'h1;
  end

  // ---------------------------------------------------------------------
  // Oscillator model: phase and segment counters.
  // ---------------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    // Pin-driven restarts wait for the clock enable so that a low enable freezes all state.
    if (sys_rst || (ce && !loop_enable))
    begin
      // A stopped oscillator restarts from a clean phase.
      seg_r <= '0;
      ph_r  <= pcf_pkg::PH_ZERO;
    end
    else if (ce)
    begin
      ph_r <= ph_nxt;
      if (rise_p || seg_r + pcf_pkg::SEG_ONE >= seg_len)
        seg_r <= '0;
      else
        seg_r <= seg_r + pcf_pkg::SEG_ONE;
    end
  end

  // ---------------------------------------------------------------------
  // Bypass hold and divider.
  // ---------------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (sys_rst || (ce && !oe_rst_n))
    begin
      // The output reset parks the bypass path low.
      hold_r    <= 1'b1;
      half_bp_r <= 1'b0;
    end
    else if (ce && fall_p)
    begin
      hold_r <= 1'b0;
      // The divider only runs once released, so it too starts low.
      if (!hold_r)
        half_bp_r <= ~half_bp_r;
    end
  end

  // ---------------------------------------------------------------------
  // Lock state machine.
  // ---------------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (sys_rst || (ce && (!loop_enable || !oe_rst_n || period == pcf_pkg::PER_MAX)))
    begin
      // Floating outputs open the feedback loop; so does a missing reference.
      lock_st_r  <= pcf_pkg::PCF_UNLOCKED;
      lock_cnt_r <= '0;
    end
    else if (ce)
    begin
      unique case (lock_st_r)
        pcf_pkg::PCF_UNLOCKED:
        begin
          // Timing starts at the first reference rising edge seen.
          if (rise_p)
            lock_st_r <= pcf_pkg::PCF_ACQUIRE;
        end
        pcf_pkg::PCF_ACQUIRE:
        begin
          // Lock is declared once the minimum acquisition time has passed.
          if (lock_cnt_r + 24'h000001 >= LOCK_CYCLES[pcf_pkg::LOCK_W-1:0])
            lock_st_r <= pcf_pkg::PCF_LOCKED;
          lock_cnt_r <= lock_cnt_r + 24'h000001;
        end
        pcf_pkg::PCF_LOCKED:
          lock_st_r <= pcf_pkg::PCF_LOCKED;
        default:
          lock_st_r <= pcf_pkg::PCF_UNLOCKED;
      endcase
    end
  end

  // ---------------------------------------------------------------------
  // Output selection between loop and bypass.
  // ---------------------------------------------------------------------
  always_comb
  begin
    if (loop_enable)
    begin
      half_v = ~ph_r[pcf_pkg::PH_HALF_BIT];
      main_v = ~ph_r[pcf_pkg::PH_MAIN_BIT];
      dbl_v  = ~ph_r[pcf_pkg::PH_DOUBLE_BIT];
      inv_v  = ~main_v;
    end
    else
    begin
      // Reference goes straight to the distribution, no frequency limit.
      main_v = hold_r ? 1'b0 : ref_in;
      half_v = hold_r ? 1'b0 : half_bp_r;
      // During the hold every output but double-rate sits low.
      inv_v  = hold_r ? 1'b0 : ~ref_in;
      dbl_v  = ~ref_in;
    end
  end

  // ---------------------------------------------------------------------
  // Registered pin drivers and enables.
  // ---------------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      main_clock_outputs    <= '0;
      inverted_clock_output <= 1'b0;
      half_rate_clock       <= 1'b0;
      double_rate_clock     <= 1'b0;
      clock_oe              <= 1'b0;
      lock_out              <= 1'b0;
    end
    else if (ce)
    begin
      main_clock_outputs    <= {pcf_pkg::MAIN_N{main_v}};
      inverted_clock_output <= inv_v;
      half_rate_clock       <= half_v;
      double_rate_clock     <= dbl_v;
      // Only the clock pins float; the lock indicator always drives.
      clock_oe              <= oe_rst_n;
      // The indicator drops with the loop state when oe_rst_n or loop_enable falls; on a missing reference it drops one cycle behind.
      lock_out              <= (lock_st_r == pcf_pkg::PCF_LOCKED)
                               && oe_rst_n && loop_enable;
    end
  end

endmodule

//--- core/pcf_pkg.sv
// Purpose: Shared constants and types for the clock fan-out model.
// Assumes: One 100 MHz system clock samples every pin.
// Notes:   Times are kept in their own unit and turned into cycles here.
package pcf_pkg;

  // ---------------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_NS = 10;     // System clock period.
  localparam int unsigned LOCK_MIN_US   = 1000;   // Earliest lock, 1.0 ms.
  localparam int unsigned LOCK_MAX_US   = 10000;  // Latest lock, 10 ms.
  // Lock is declared at the earliest allowed time, rounded up.
  localparam int unsigned LOCK_MIN_CYC  =
    (LOCK_MIN_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned LOCK_MAX_CYC  = (LOCK_MAX_US * 1000) / CLK_PERIOD_NS;

  // ---------------------------------------------------------------------
  // Widths and fixed values
  // ---------------------------------------------------------------------
  localparam int unsigned PER_W   = 16;           // Reference period counter width.
  localparam int unsigned LOCK_W  = 24;           // Lock timer width.
  localparam int unsigned MAIN_N  = 5;            // Number of main clock outputs.
  localparam logic [PER_W-1:0] PER_MAX  = 16'hffff; // Period saturation value.
  localparam logic [PER_W-1:0] SEG_ONE  = 16'h0001; // Shortest segment length.
  localparam logic [2:0]       PH_ZERO  = 3'h0;     // Phase at reset.
  // Bit of the phase counter that carries each output.
  localparam int unsigned PH_HALF_BIT   = 2;
  localparam int unsigned PH_MAIN_BIT   = 1;
  localparam int unsigned PH_DOUBLE_BIT = 0;

  // Which output is wired back to the feedback input.
  typedef enum logic [1:0] {
    PCF_FB_HALF   = 2'b00,
    PCF_FB_MAIN   = 2'b01,
    PCF_FB_DOUBLE = 2'b10
  } pcf_fb_type;

  // Loop lock state.
  typedef enum logic [1:0] {
    PCF_UNLOCKED = 2'b00,
    PCF_ACQUIRE  = 2'b01,
    PCF_LOCKED   = 2'b10
  } pcf_lock_type;

endpackage

//--- core/pcf_ref_meter.sv
// Purpose: Edge detection and period measurement of the selected reference.
// Assumes: The reference level is synchronous to clk.
// Notes:   Period is counted rise to rise and saturates when the reference stops.
`timescale 1ns/1ps
module pcf_ref_meter (
  input  wire logic                      clk,
  input  wire logic                      sys_rst,
  input  wire logic                      ce,
  input  wire logic                      ref_in,
  output logic                           rise_p,
  output logic                           fall_p,
  output logic [pcf_pkg::PER_W-1:0]      period_r
);

  logic                     level_r;  // Reference level one cycle ago.
  logic [pcf_pkg::PER_W-1:0] count_r; // Cycles since the last rising edge.

  // Edges are seen against the previous level only.
  assign rise_p = ce & ref_in & ~level_r;
  assign fall_p = ce & ~ref_in & level_r;

  // ---------------------------------------------------------------------
  // Level history.
  // ---------------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (sys_rst)
      level_r <= 1'b0;
    else if (ce)
      level_r <= ref_in;
  end

  // ---------------------------------------------------------------------
  // Period counter: captured on every rising edge, then restarted.
  // ---------------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      count_r  <= '0;
      period_r <= pcf_pkg::PER_MAX;
    end
    else if (rise_p)
    begin
      // The edge cycle itself is counted, so the period is count plus one.
      period_r <= count_r + pcf_pkg::SEG_ONE;
      count_r  <= '0;
    end
    else if (ce)
    begin
      // A reference that stops shows as a saturated period, which unlocks the loop.
      if (count_r != pcf_pkg::PER_MAX)
        count_r <= count_r + pcf_pkg::SEG_ONE;
      else
        period_r <= pcf_pkg::PER_MAX;
    end
  end

endmodule

//--- dv/pcf_board_model.sv
// Purpose: Board-side reference sources that feed the fan-out model.
// Assumes: Both references change just after clk rises.
// Notes:   The second reference has an uneven duty and can be parked high.
`timescale 1ns/1ps
module pcf_board_model #(
  parameter int unsigned PER0 = 16, // Period of the first reference, in cycles.
  parameter int unsigned PER1 = 24, // Period of the second reference, in cycles.
  parameter int unsigned LO1  = 10  // Low time of the second reference, in cycles.
) (
  input  wire logic clk,
  input  wire logic hold1,
  output logic      ref_clk0,
  output logic      ref_clk1
);
  int unsigned c0 = 0; // Phase of the first reference.
  int unsigned c1 = 0; // Phase of the second reference.
  // ---------------------------------------------------------------------
  // Reference generation
  // ---------------------------------------------------------------------
  // Phases move just after the edge so the device never samples a change.
  always @(posedge clk)
  begin
    c0 <= (c0 + 1) % PER0;
    c1 <= hold1 ? 0 : (c1 + 1) % PER1;
  end
  assign ref_clk0 = (c0 < PER0 / 2);       // Even duty for loop mode.
  assign ref_clk1 = hold1 | (c1 >= LO1);   // Uneven duty; in bypass its falls release the hold and step the half-rate divider.
endmodule

//--- dv/pcf_fanout_asserts.sv
// Purpose: Port-level checker for the clock fan-out model.
// Assumes: One clock domain, synchronous active-high reset.
// Notes:   The lock window counter restarts whenever the loop is disabled or the outputs are floated, not on a missing reference.
`timescale 1ns/1ps
module pcf_fanout_chk #(
  parameter int unsigned LOCK_CYCLES = 200 // Lock acquisition time.
) (
  input wire logic                      clk,
  input wire logic                      sys_rst,
  input wire logic                      ce,
  input wire logic                      ref_clk0,
  input wire logic                      ref_clk1,
  input wire logic                      ref_sel,
  input wire logic                      loop_enable,
  input wire logic [1:0]                fb_sel,
  input wire logic                      oe_rst_n,
  input wire logic [pcf_pkg::MAIN_N-1:0] main_clock_outputs,
  input wire logic                      inverted_clock_output,
  input wire logic                      half_rate_clock,
  input wire logic                      double_rate_clock,
  input wire logic                      clock_oe,
  input wire logic                      lock_out
);
  logic        sel_ref;   // Reference that the select pin picks.
  logic        fb_out;    // Output that the feedback choice names.
  logic [23:0] run_cnt_r; // Cycles since the loop was last closed.
  assign sel_ref = ref_sel ? ref_clk1 : ref_clk0;
  assign fb_out = (fb_sel == 2'b00) ? half_rate_clock :
                  (fb_sel == 2'b10) ? double_rate_clock : main_clock_outputs[0];
  // ---------------------------------------------------------------------
  // Helper logic
  // ---------------------------------------------------------------------
  // Saturating, so a long locked run cannot wrap and fake an early lock.
  always_ff @(posedge clk)
  begin
    if (sys_rst || !loop_enable || !oe_rst_n)
      run_cnt_r <= 24'h000000;
    else if (ce && run_cnt_r != 24'hffffff)
      run_cnt_r <= run_cnt_r + 24'h000001;
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  // Bypass entered with the pins floated, then released with the reference high.
  sequence released_high;
    (ce && !loop_enable && !oe_rst_n) ##1 (ce && !loop_enable && oe_rst_n && sel_ref)[*2];
  endsequence
  // ---------------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------------
  oe_float_a: assert property ((ce && !oe_rst_n) |=> !clock_oe)
    else $error("clock pins driven while output enable low");
  lock_loss_a: assert property ((ce && !oe_rst_n) |=> !lock_out)
    else $error("lock kept while outputs floated");
  bypass_unlock_a: assert property ((ce && !loop_enable) |=> !lock_out)
    else $error("lock shown with the loop disabled");
  bypass_double_a: assert property ((ce && !loop_enable && oe_rst_n)
    |=> double_rate_clock == !$past(sel_ref)) else $error("double rate not inverted ref");
  bypass_hold_a: assert property (released_high |=> main_clock_outputs == '0
    && !inverted_clock_output && !half_rate_clock) else $error("outputs left low hold");
  inv_opp_a: assert property (lock_out |-> inverted_clock_output != main_clock_outputs[0])
    else $error("inverted output not opposite main");
  main_same_a: assert property (main_clock_outputs == '0 || main_clock_outputs == '1)
    else $error("main outputs disagree");
  // The realigned phase reaches the registered pins two enabled cycles after the rise.
  fb_align_a: assert property ((lock_out && ce && $past(ce) && loop_enable && oe_rst_n
    && sel_ref && !$past(sel_ref)) ##1 (ce && loop_enable) |=> $rose(fb_out))
    else $error("feedback rise not aligned to reference");
  lock_min_a: assert property (lock_out |-> run_cnt_r >= 24'(LOCK_CYCLES - 1))
    else $error("lock shown too early");
  lock_max_a: assert property ((run_cnt_r == 24'(LOCK_CYCLES + 64)) |-> lock_out)
    else $error("lock not regained in time");
endmodule

bind pcf_fanout pcf_fanout_chk #(.LOCK_CYCLES(LOCK_CYCLES)) u_chk (.clk(clk),
  .sys_rst(sys_rst), .ce(ce), .ref_clk0(ref_clk0), .ref_clk1(ref_clk1), .ref_sel(ref_sel),
  .loop_enable(loop_enable), .fb_sel(fb_sel), .oe_rst_n(oe_rst_n),
  .main_clock_outputs(main_clock_outputs), .inverted_clock_output(inverted_clock_output),
  .half_rate_clock(half_rate_clock), .double_rate_clock(double_rate_clock),
  .clock_oe(clock_oe), .lock_out(lock_out));

//--- dv/pcf_fanout_bench.sv
// Purpose: Self-checking bench for the clock fan-out model.
// Assumes: Lock time shortened to LOCKC cycles; reference period PER0.
// Notes:   Rise counts use a window that holds whole periods of every output.
`timescale 1ns/1ps
module pcf_fanout_bench;
  localparam int unsigned LOCKC = 200; // Shortened lock time.
  localparam int unsigned PER0  = 16;  // Loop-mode reference period.
  logic clk, sys_rst, ce, ref_sel, loop_enable, oe_rst_n, hold1; // Driven pins.
  logic [1:0]                 fb_sel;      // Feedback choice.
  logic                       ref_clk0, ref_clk1; // Board references.
  logic [pcf_pkg::MAIN_N-1:0] main_clock_outputs; // Main clocks.
  logic inverted_clock_output, half_rate_clock, double_rate_clock, clock_oe, lock_out;
  int miscompares = 0; // Mismatch count.
  int compares    = 0; // Comparison count.

  pcf_fanout #(.LOCK_CYCLES(LOCKC)) dut (.clk(clk), .sys_rst(sys_rst), .ce(ce),
    .ref_clk0(ref_clk0), .ref_clk1(ref_clk1), .ref_sel(ref_sel), .loop_enable(loop_enable),
    .fb_sel(fb_sel), .oe_rst_n(oe_rst_n), .main_clock_outputs(main_clock_outputs),
    .inverted_clock_output(inverted_clock_output), .half_rate_clock(half_rate_clock),
    .double_rate_clock(double_rate_clock), .clock_oe(clock_oe), .lock_out(lock_out));
  pcf_board_model #(.PER0(PER0)) board (.clk(clk), .hold1(hold1), .ref_clk0(ref_clk0),
    .ref_clk1(ref_clk1));

  // ---------------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------------
  // Sampling waits 1 ns past the edge so registered outputs have settled.
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic chk_val(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp)
    begin
      miscompares++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_cnt(input int got, input int exp);
    compares++;
    if (got != exp)
    begin
      miscompares++;
      $display("[ERR] %0t count %0d expected %0d", $time, got, exp);
    end
  endtask
  task automatic final_report;
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // ---------------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------------
  // Bypass: floated pins, low hold with the reference parked high, then following.
  task automatic t_bypass;
    @(posedge clk);
    loop_enable <= 1'b0;
    ref_sel <= 1'b1;
    hold1 <= 1'b1;
    oe_rst_n <= 1'b0;
    cyc(3);
    chk_val({6'h00, clock_oe, lock_out}, 8'h00);
    @(posedge clk);
    oe_rst_n <= 1'b1;
    cyc(6);
    chk_val({main_clock_outputs, inverted_clock_output, half_rate_clock,
             double_rate_clock}, 8'h00);
    chk_val({7'h00, clock_oe}, 8'h01);
    @(posedge clk);
    hold1 <= 1'b0;
    cyc(4);
    chk_val({main_clock_outputs, inverted_clock_output, half_rate_clock,
             double_rate_clock}, 8'h05);
    cyc(10);
    chk_val({main_clock_outputs, inverted_clock_output, half_rate_clock,
             double_rate_clock}, 8'hf8);
    cyc(14);
    chk_val({main_clock_outputs, inverted_clock_output, half_rate_clock,
             double_rate_clock}, 8'h07);
  endtask
  // Loop mode with one feedback choice: break, relock, then count output rises.
  task automatic t_loop(input logic [1:0] f, input int eh, input int em, input int ed);
    int n;
    int k;
    int c [4];
    logic [3:0] p;
    logic [3:0] v;
    @(posedge clk);
    oe_rst_n <= 1'b0;
    fb_sel <= f;
    loop_enable <= 1'b1;
    ref_sel <= 1'b0;
    cyc(2);
    chk_val({6'h00, clock_oe, lock_out}, 8'h00);
    @(posedge clk);
    oe_rst_n <= 1'b1;
    n = 0;
    while (lock_out !== 1'b1 && n < int'(LOCKC) + 64)
    begin
      cyc(1);
      n++;
    end
    chk_cnt(int'(n >= int'(LOCKC) - 1 && lock_out === 1'b1), 1);
    if (lock_out !== 1'b1)
      final_report();
    c = '{0, 0, 0, 0};
    p = {half_rate_clock, main_clock_outputs[0], inverted_clock_output, double_rate_clock};
    repeat (8 * PER0)
    begin
      cyc(1);
      v = {half_rate_clock, main_clock_outputs[0], inverted_clock_output, double_rate_clock};
      for (k = 0; k < 4; k++)
        c[k] += int'(v[k] & ~p[k]);
      p = v;
    end
    chk_cnt(c[3], eh);
    chk_cnt(c[2], em);
    chk_cnt(c[1], em);
    chk_cnt(c[0], ed);
  endtask
  // Clock enable low: every output holds its value and lock stays shown.
  task automatic t_freeze;
    logic [7:0] held;
    @(posedge clk);
    ce <= 1'b0;
    cyc(1);
    held = {main_clock_outputs, inverted_clock_output, half_rate_clock, double_rate_clock};
    cyc(20);
    chk_val({main_clock_outputs, inverted_clock_output, half_rate_clock,
             double_rate_clock}, held);
    chk_val({6'h00, clock_oe, lock_out}, 8'h03);
    @(posedge clk);
    ce <= 1'b1;
  endtask

  // ---------------------------------------------------------------------
  // Clock and main sequence
  // ---------------------------------------------------------------------
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial
  begin
    sys_rst = 1'b1;
    ce = 1'b1;
    ref_sel = 1'b0;
    loop_enable = 1'b1;
    fb_sel = 2'b00;
    oe_rst_n = 1'b1;
    hold1 = 1'b0;
    repeat (5) @(posedge clk);
    sys_rst <= 1'b0;
    t_bypass();
    t_loop(2'b00, 8, 16, 32);
    t_loop(2'b01, 4, 8, 16);
    t_loop(2'b10, 2, 4, 8);
    t_loop(2'b11, 4, 8, 16);
    t_freeze();
    final_report();
  end
endmodule
